// ==== logic/cstb_top.sv ====
// clock security, reset cause flags and time base with an AHB-Lite slave
// How it works
// - guardEnable low turns off spike filter and safe clock fallback together
// - oscillator levels shorter than the least half period are filtered out
// - harmonic clock is fully suppressed; filter releases once halves are wide
// - no filtered edge for one safe period selects the backup clock
// - a few good edges return the system to the original oscillator
// - backup selection sets clock_loss_detected; irq only if enable set
// - clock_loss_detected clears on status read once oscillator recovered
// - guard disabled: detected flag reads 0, its enable is ignored
// - low voltage flag set by low voltage reset, cleared by writing zero
// - watchdog flag set by watchdog reset, cleared by zero write or lvd reset
// - flags 00 external, 01 watchdog, 1x low voltage
// - low voltage flag survives later external or watchdog resets
// - status register bits 7:5 and 3 read zero
// - time base select picks 32000, 64000, 160000 or 400000 cycles
// - new time base selection applies at the end of the running period
// - elapsed flag set at each period end, cleared by control register read
// - time base interrupt enable also wakes from oscillator-kept stop
// - stop with time base irq enabled enters oscillator-kept stop
// - prescaler held as two select bits and a slow mode bit
// - clock-out pin gives oscillator over two when enabled
// - clock-out halts during oscillator-kept stop
// - control register bits 7:4 read zero
// - cpu tick runs at oscillator over two
module cstb_top #(
   parameter int unsigned TB_DIV0 = cstb_pkg::TB_DIV_0,
   parameter int unsigned TB_DIV1 = cstb_pkg::TB_DIV_1,
   parameter int unsigned TB_DIV2 = cstb_pkg::TB_DIV_2,
   parameter int unsigned TB_DIV3 = cstb_pkg::TB_DIV_3,
   parameter int unsigned SAFE_HALF = cstb_pkg::SAFE_HALF_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // option and reset manager
   input wire logic guardEnable,
   input wire logic lvdResetEvt,
   input wire logic wdgResetEvt,
   // oscillator pin
   input wire logic oscPin,
   // power modes
   input wire logic stopReq,
   input wire logic wakeEvt,
   // clock results
   output logic cpuTick,
   output logic clkOut,
   output logic [1:0] prescaleSel,
   output logic slowMode,
   output logic safeActive,
   output logic activeHalt,
   output logic fullHalt,
   output logic irq
);
   import cstb_pkg::*;
   localparam int TBW = $clog2(TB_DIV3);

   function automatic cstb_sel_t regSel(input logic [31:0] a);
      if (a == ADDR_CLK_CTRL) begin
         regSel = SEL_CC;
      end else if (a == ADDR_RST_STAT) begin
         regSel = SEL_RS;
      end else if (a == ADDR_MISC_ONE) begin
         regSel = SEL_MISC;
      end else begin
         regSel = SEL_NONE;
      end
   endfunction : regSel

   function automatic logic [TBW-1:0] divLimit(input logic [1:0] sel);
      case (sel)
         2'h0: divLimit = TBW'(TB_DIV0 - 1);
         2'h1: divLimit = TBW'(TB_DIV1 - 1);
         2'h2: divLimit = TBW'(TB_DIV2 - 1);
         default: divLimit = TBW'(TB_DIV3 - 1);
      endcase
   endfunction : divLimit

   logic oscLevel, oscTick, safeNow, lossEvt;
   logic take, rdTake, wrTake, rdCc, rdRs, wrCc, wrRs, wrMisc;
   logic tbExpire, irqD;
   logic [7:0] wd, ccView, rsView, msView;
   cstb_sel_t wrSel_q, rdSelNow;
   cstb_pwr_t pwr_q, pwrD;
   logic [1:0] tbSel_q, tbSelRun_q, pre_q;
   logic tbIe_q, tbElapsed_q, slow_q, outEn_q;
   logic rsLvd_q, rsWdg_q, rsLoss_q, rsLossIe_q;
   logic [TBW-1:0] tbCnt_q;
   logic [31:0] rdata_q;
   logic ready_q, resp_q, irq_q, cpuTick_q, cpuPhase_q, clkOut_q;
   logic actHalt_q, fullHalt_q;

   cstb_sync #(.WIDTH(1)) oscSync (
      .clk(clk),
      .rst_n(rst_n),
      .din(oscPin),
      .dout(oscLevel)
   );

   cstb_guard #(.SAFE_HALF(SAFE_HALF)) guard (
      .clk(clk),
      .rst_n(rst_n),
      .oscLevel(oscLevel),
      .guardEnable(guardEnable),
      .oscTick(oscTick),
      .safeActive(safeNow),
      .lossPulse(lossEvt)
   );

   // bus decode; only whole word transfers act
   assign take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
   assign rdTake = take & ~hwrite;
   assign wrTake = take & hwrite;
   assign rdSelNow = regSel(haddr);
   assign rdCc = rdTake && rdSelNow == SEL_CC;
   assign rdRs = rdTake && rdSelNow == SEL_RS;
   assign wd = hwdata[7:0];
   assign wrCc = wrSel_q == SEL_CC;
   assign wrRs = wrSel_q == SEL_RS;
   assign wrMisc = wrSel_q == SEL_MISC;

   assign ccView = {4'h0, tbSel_q, tbIe_q, tbElapsed_q};
   // loss flag masked when the guard is off
   assign rsView = {3'h0, rsLvd_q, 1'b0, rsLossIe_q, rsLoss_q & guardEnable, rsWdg_q};
   assign msView = {4'h0, outEn_q, pre_q, slow_q};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrSel_q <= SEL_NONE;
         rdata_q <= 32'h0;
         ready_q <= 1'b1;
         resp_q <= HRESP_OKAY;
      end else begin
         wrSel_q <= wrTake ? rdSelNow : SEL_NONE;
         ready_q <= 1'b1;
         resp_q <= HRESP_OKAY;
         case (rdTake ? rdSelNow : SEL_NONE)
            SEL_CC: rdata_q <= {24'h0, ccView};
            SEL_RS: rdata_q <= {24'h0, rsView};
            SEL_MISC: rdata_q <= {24'h0, msView};
            default: rdata_q <= 32'h0;
         endcase
      end
   end

   // time base counter on oscillator ticks
   assign tbExpire = oscTick && tbCnt_q == divLimit(tbSelRun_q);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tbCnt_q <= '0;
         tbSelRun_q <= 2'h0;
      end else if (tbExpire) begin
         tbCnt_q <= '0;
         tbSelRun_q <= tbSel_q;
      end else if (oscTick) begin
         tbCnt_q <= tbCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tbSel_q <= CC_RESET[CC_TB_SEL_HI:CC_TB_SEL_LO];
         tbIe_q <= CC_RESET[CC_TB_IRQ_EN];
      end else if (wrCc) begin
         tbSel_q <= wd[CC_TB_SEL_HI:CC_TB_SEL_LO];
         tbIe_q <= wd[CC_TB_IRQ_EN];
      end
   end

   // a fresh expiry wins over the clearing read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tbElapsed_q <= CC_RESET[CC_ELAPSED];
      end else if (tbExpire) begin
         tbElapsed_q <= 1'b1;
      end else if (rdCc) begin
         tbElapsed_q <= 1'b0;
      end
   end

   // rst_n is power-on only; other resets arrive as event pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsLvd_q <= RS_RESET[RS_LVD];
         rsWdg_q <= RS_RESET[RS_WDG];
      end else begin
         if (lvdResetEvt) begin
            rsLvd_q <= 1'b1;
         end else if (wrRs && !wd[RS_LVD]) begin
            rsLvd_q <= 1'b0;
         end
         if (wdgResetEvt) begin
            rsWdg_q <= 1'b1;
         end else if (lvdResetEvt || (wrRs && !wd[RS_WDG])) begin
            rsWdg_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsLoss_q <= RS_RESET[RS_LOSS];
      end else if (!guardEnable) begin
         rsLoss_q <= 1'b0;
      end else if (lossEvt) begin
         rsLoss_q <= 1'b1;
      end else if (rdRs && !safeNow) begin
         rsLoss_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsLossIe_q <= RS_RESET[RS_LOSS_IRQ_EN];
      end else if (wrRs) begin
         rsLossIe_q <= wd[RS_LOSS_IRQ_EN];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_q <= MS_RESET[MS_SLOW];
         pre_q <= MS_RESET[MS_PRE_HI:MS_PRE_LO];
         outEn_q <= MS_RESET[MS_CLK_OUT];
      end else if (wrMisc) begin
         slow_q <= wd[MS_SLOW];
         pre_q <= wd[MS_PRE_HI:MS_PRE_LO];
         outEn_q <= wd[MS_CLK_OUT];
      end
   end

   // shared interrupt request
   assign irqD = (rsLoss_q & rsLossIe_q & guardEnable) | (tbElapsed_q & tbIe_q);

   // power modes; in run a stop request is taken even with a wake in the same cycle
   always_comb begin
      pwrD = pwr_q;
      case (pwr_q)
         PWR_RUN: begin
            if (stopReq) begin
               pwrD = tbIe_q ? PWR_ACTIVE_HALT : PWR_FULL_HALT;
            end
         end
         PWR_ACTIVE_HALT: begin
            if (wakeEvt || irqD) begin
               pwrD = PWR_RUN;
            end
         end
         PWR_FULL_HALT: begin
            if (wakeEvt) begin
               pwrD = PWR_RUN;
            end
         end
         default: pwrD = PWR_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_q <= PWR_RUN;
         actHalt_q <= 1'b0;
         fullHalt_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         pwr_q <= pwrD;
         actHalt_q <= pwrD == PWR_ACTIVE_HALT;
         fullHalt_q <= pwrD == PWR_FULL_HALT;
         irq_q <= irqD;
      end
   end

   // cpu tick and clock-out both divide the selected oscillator by two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpuPhase_q <= 1'b0;
         cpuTick_q <= 1'b0;
         clkOut_q <= 1'b0;
      end else begin
         if (oscTick) begin
            cpuPhase_q <= ~cpuPhase_q;
         end
         cpuTick_q <= oscTick & cpuPhase_q & (pwr_q == PWR_RUN);
         if (!outEn_q) begin
            clkOut_q <= 1'b0;
         end else if (oscTick && pwr_q != PWR_ACTIVE_HALT) begin
            clkOut_q <= ~clkOut_q;
         end
      end
   end

   assign hrdata = rdata_q;
   assign hreadyout = ready_q;
   assign hresp = resp_q;
   assign cpuTick = cpuTick_q;
   assign clkOut = clkOut_q;
   assign prescaleSel = pre_q;
   assign slowMode = slow_q;
   assign safeActive = safeNow;
   assign activeHalt = actHalt_q;
   assign fullHalt = fullHalt_q;
   assign irq = irq_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   guard_off_a: assert property (
      !guardEnable |=> !safeActive) else $error("safe clock active with guard off");
   loss_flag_a: assert property (
      guardEnable && lossEvt |=> rsLoss_q) else $error("loss flag not set");
   loss_clear_a: assert property (
      guardEnable && rdRs && !safeNow && !lossEvt |=> !rsLoss_q)
      else $error("loss flag not cleared by read");
   loss_mask_a: assert property (
      !guardEnable |=> !rsView[RS_LOSS]) else $error("loss flag visible with guard off");
   lvd_keep_a: assert property (
      rsLvd_q && !(wrRs && !wd[RS_LVD]) |=> rsLvd_q) else $error("lvd flag lost");
   wdg_clear_a: assert property (
      lvdResetEvt && !wdgResetEvt |=> !rsWdg_q) else $error("wdg flag kept over lvd");
   rsv_zero_a: assert property (
      rdRs |=> hrdata[31:5] == 27'h0 && !hrdata[3]) else $error("reserved bit set");
   tb_period_a: assert property (
      tbExpire |=> tbElapsed_q && tbCnt_q == '0) else $error("period end missed");
   tb_change_a: assert property (
      !tbExpire |=> $stable(tbSelRun_q)) else $error("time base changed mid period");
   tb_read_a: assert property (
      rdCc && !tbExpire |=> !tbElapsed_q) else $error("elapsed flag not cleared");
   halt_sel_a: assert property (
      pwr_q == PWR_RUN && stopReq |=> (activeHalt == $past(tbIe_q))
         && (fullHalt == !$past(tbIe_q)))
      else $error("wrong stop mode");
   clkout_halt_a: assert property (
      pwr_q == PWR_ACTIVE_HALT && outEn_q |=> $stable(clkOut))
      else $error("clock-out ran in halt");
   irq_tie_a: assert property (
      tbElapsed_q && tbIe_q |=> irq) else $error("time base irq missing");

   safe_entry_c: cover property (lossEvt ##[1:1000] !safeActive);
   tb_expire_c: cover property (tbExpire ##1 rdCc);
   act_halt_c: cover property (activeHalt ##[1:1000] !activeHalt);
endmodule : cstb_top

// ==== inc/cstb_pkg.sv ====
// constants and types shared by the clock security and time base block
package cstb_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_CLK_CTRL = 8'h29;
   localparam logic [7:0] IDX_RST_STAT = 8'h2B;
   localparam logic [7:0] IDX_MISC_ONE = 8'h2C;
   localparam logic [31:0] ADDR_CLK_CTRL = {22'h0, IDX_CLK_CTRL, 2'h0};
   localparam logic [31:0] ADDR_RST_STAT = {22'h0, IDX_RST_STAT, 2'h0};
   localparam logic [31:0] ADDR_MISC_ONE = {22'h0, IDX_MISC_ONE, 2'h0};
   // clock_control_status fields
   localparam int CC_ELAPSED = 0;
   localparam int CC_TB_IRQ_EN = 1;
   localparam int CC_TB_SEL_LO = 2;
   localparam int CC_TB_SEL_HI = 3;
   localparam logic [7:0] CC_RESET = 8'h01;
   // reset_clock_supply_status fields
   localparam int RS_WDG = 0;
   localparam int RS_LOSS = 1;
   localparam int RS_LOSS_IRQ_EN = 2;
   localparam int RS_LVD = 4;
   localparam logic [7:0] RS_RESET = 8'h00;
   // misc_control_one fields
   localparam int MS_SLOW = 0;
   localparam int MS_PRE_LO = 1;
   localparam int MS_PRE_HI = 2;
   localparam int MS_CLK_OUT = 3;
   localparam logic [7:0] MS_RESET = 8'h00;
   // time base divisions in oscillator cycles
   localparam int unsigned TB_DIV_0 = 32000;
   localparam int unsigned TB_DIV_1 = 64000;
   localparam int unsigned TB_DIV_2 = 160000;
   localparam int unsigned TB_DIV_3 = 400000;
   // spike filter least half period, rounded up
   localparam int unsigned SPIKE_MIN_NS = 24;
   localparam int unsigned SPIKE_MIN_CYC = (SPIKE_MIN_NS * CLK_MHZ + 999) / 1000;
   // safe oscillator half period
   localparam int unsigned SAFE_HALF_NS = 2000;
   localparam int unsigned SAFE_HALF_CYC = SAFE_HALF_NS * CLK_MHZ / 1000;
   localparam int unsigned RECOVER_EDGES = 4;
   // bus
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;
   typedef enum logic [1:0] {SEL_NONE, SEL_CC, SEL_RS, SEL_MISC} cstb_sel_t;
   typedef enum logic [1:0] {PWR_RUN, PWR_ACTIVE_HALT, PWR_FULL_HALT} cstb_pwr_t;
endpackage : cstb_pkg

// ==== logic/cstb_sync.sv ====
// two flip-flop synchroniser for pin levels
module cstb_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule : cstb_sync

// ==== logic/cstb_guard.sv ====
// oscillator spike filter, loss detector and safe clock source
module cstb_guard #(
   parameter int unsigned MIN_HALF = cstb_pkg::SPIKE_MIN_CYC,
   parameter int unsigned SAFE_HALF = cstb_pkg::SAFE_HALF_CYC,
   parameter int unsigned RECOVER = cstb_pkg::RECOVER_EDGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // oscillator level and option
   input wire logic oscLevel,
   input wire logic guardEnable,
   // results
   output logic oscTick,
   output logic safeActive,
   output logic lossPulse
);
   import cstb_pkg::*;
   localparam int unsigned LOSS = 2 * SAFE_HALF;
   localparam int WW = $clog2(MIN_HALF + 1);
   localparam int LW = $clog2(LOSS + 1);
   localparam int SW = $clog2(SAFE_HALF + 1);
   localparam int GW = $clog2(RECOVER + 1);
   logic rawLast_q, filt_q, filtD, safe_q, safeClk_q, tick_q, loss_q;
   logic filtRise, safeRise, lossHit, lostSat;
   logic [WW-1:0] width_q;
   logic [LW-1:0] lossCnt_q;
   logic [SW-1:0] safeCnt_q;
   logic [GW-1:0] good_q;

   // with the guard on, filtered level follows only a level held for the least half period; with it off, it follows oscLevel directly
   always_comb begin
      filtD = filt_q;
      if (!guardEnable) begin
         filtD = oscLevel;
      end else if (width_q == WW'(MIN_HALF)) begin
         filtD = rawLast_q;
      end
   end

   assign filtRise = filtD & ~filt_q;
   assign lostSat = lossCnt_q == LW'(LOSS);
   assign lossHit = guardEnable & ~safe_q & lostSat;
   assign safeRise = safe_q & ~safeClk_q & (safeCnt_q == SW'(SAFE_HALF - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rawLast_q <= 1'b0;
         filt_q <= 1'b0;
         width_q <= '0;
      end else begin
         rawLast_q <= oscLevel;
         filt_q <= filtD;
         if (oscLevel != rawLast_q) begin
            width_q <= '0;
         end else if (width_q != WW'(MIN_HALF)) begin
            width_q <= width_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lossCnt_q <= '0;
         good_q <= '0;
         safe_q <= 1'b0;
      end else begin
         if (filtRise) begin
            lossCnt_q <= '0;
         end else if (!lostSat) begin
            lossCnt_q <= lossCnt_q + 1'b1;
         end
         if (!safe_q) begin
            good_q <= '0;
         end else if (filtRise) begin
            good_q <= good_q + 1'b1;
         end else if (lostSat) begin
            good_q <= '0;
         end
         if (!guardEnable) begin
            safe_q <= 1'b0;
         end else if (lossHit) begin
            safe_q <= 1'b1;
         end else if (filtRise && good_q == GW'(RECOVER - 1)) begin
            safe_q <= 1'b0;
         end
      end
   end

   // low frequency backup clock, only running while selected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         safeCnt_q <= '0;
         safeClk_q <= 1'b0;
      end else if (!safe_q) begin
         safeCnt_q <= '0;
         safeClk_q <= 1'b0;
      end else if (safeCnt_q == SW'(SAFE_HALF - 1)) begin
         safeCnt_q <= '0;
         safeClk_q <= ~safeClk_q;
      end else begin
         safeCnt_q <= safeCnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 1'b0;
         loss_q <= 1'b0;
      end else begin
         tick_q <= safe_q ? safeRise : filtRise;
         loss_q <= lossHit;
      end
   end

   assign oscTick = tick_q;
   assign safeActive = safe_q;
   assign lossPulse = loss_q;
endmodule : cstb_guard

// ==== verification/cstb_osc_model.sv ====
// oscillator source model driving the block's clock pin
module cstb_osc_model (
   // control
   input wire logic run,
   input wire logic [31:0] halfNs,
   // pin
   output logic oscPin
);
   timeunit 1ns;
   timeprecision 100ps;
   // 1 ns offset keeps pin edges away from system clock edges
   initial begin
      oscPin = 1'h0;
      #1;
      forever begin
         if (run) begin
            #(halfNs) oscPin = ~oscPin;
         end else begin
            // a dead resonator sits low
            oscPin = 1'h0;
            #4;
         end
      end
   end
endmodule : cstb_osc_model

// ==== verification/cstb_top_tb.sv ====
// self-checking bench for the clock security and time base block
module cstb_top_tb
   import cstb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DV [4] = '{8, 16, 40, 100};
   localparam int OSC_CYC = 20;
   localparam int P_WDG = 0;
   localparam int P_LVD = 1;
   localparam int P_STOP = 2;
   localparam int P_WAKE = 3;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, oscRun;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, prescaleSel;
   logic [2:0] hsize;
   logic guardEnable, lvdResetEvt, wdgResetEvt, oscPin, stopReq, wakeEvt;
   logic cpuTick, clkOut, slowMode, safeActive, activeHalt, fullHalt, irq;
   int oscHalf, riseCyc;
   int cyc = 0;
   int n_fail = 0;
   int n_tests = 0;

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   cstb_top #(.TB_DIV0(DV[0]), .TB_DIV1(DV[1]), .TB_DIV2(DV[2]), .TB_DIV3(DV[3]),
      .SAFE_HALF(40)) uut (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .guardEnable(guardEnable), .lvdResetEvt(lvdResetEvt), .wdgResetEvt(wdgResetEvt),
      .oscPin(oscPin), .stopReq(stopReq), .wakeEvt(wakeEvt), .cpuTick(cpuTick),
      .clkOut(clkOut), .prescaleSel(prescaleSel), .slowMode(slowMode),
      .safeActive(safeActive), .activeHalt(activeHalt), .fullHalt(fullHalt), .irq(irq));

   cstb_osc_model osc (.run(oscRun), .halfNs(oscHalf), .oscPin(oscPin));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // one single word transfer; entered just after a rising edge
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
      output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask : xfer

   task automatic wrReg(input logic [31:0] addr, input logic [7:0] v);
      logic [31:0] r;
      xfer(1'h1, addr, {24'h0, v}, r);
   endtask : wrReg

   task automatic rdChk(input logic [31:0] addr, input logic [7:0] exp);
      logic [31:0] r;
      xfer(1'h0, addr, 32'h0, r);
      chk(r, {24'h0, exp}, "register read");
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
   endtask : rdChk

   task automatic waitSig(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, s}, {31'h0, v}, "bounded wait");
   endtask : waitSig

   // one-cycle event on the chosen input; named drive keeps the assignment non-blocking
   task automatic pulse(input int which);
      case (which)
         P_WDG: wdgResetEvt <= 1'h1;
         P_LVD: lvdResetEvt <= 1'h1;
         P_STOP: stopReq <= 1'h1;
         default: wakeEvt <= 1'h1;
      endcase
      @(posedge clk);
      wdgResetEvt <= 1'h0;
      lvdResetEvt <= 1'h0;
      stopReq <= 1'h0;
      wakeEvt <= 1'h0;
   endtask : pulse

   // reading clears the elapsed flag, then the next rise is timed
   task automatic period(input int cycles, input logic [1:0] sel);
      logic [31:0] r;
      xfer(1'h0, ADDR_CLK_CTRL, 32'h0, r);
      chk(r, {28'h0, sel, 2'h3}, "control read");
      waitSig(irq, 1'h0, 10);
      waitSig(irq, 1'h1, 2500);
      chk(32'(cyc - riseCyc), 32'(cycles), "time base period");
      riseCyc = cyc;
   endtask : period

   task automatic gap(ref logic s, input int exp);
      int c;
      waitSig(s, 1'h1, 100);
      c = cyc;
      waitSig(s, 1'h0, 100);
      waitSig(s, 1'h1, 100);
      chk(32'(cyc - c), 32'(exp), "rise to rise");
   endtask : gap

   task automatic endTest(input string name);
      $display("test %s finished", name);
   endtask : endTest

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // whole run needs about 7.5k cycles
   initial begin
      #200000;
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      logic [31:0] r;
      rst_n = 1'h0;
      hsel = 1'h1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      guardEnable = 1'h0;
      lvdResetEvt = 1'h0;
      wdgResetEvt = 1'h0;
      stopReq = 1'h0;
      wakeEvt = 1'h0;
      oscRun = 1'h0;
      oscHalf = 40;
      riseCyc = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rdChk(ADDR_CLK_CTRL, CC_RESET);
      rdChk(ADDR_RST_STAT, RS_RESET);
      rdChk(ADDR_MISC_ONE, MS_RESET);
      rdChk(32'h100, 8'h00);
      wrReg(ADDR_CLK_CTRL, 8'hFF);
      rdChk(ADDR_CLK_CTRL, 8'h0E);
      wrReg(ADDR_RST_STAT, 8'hFF);
      rdChk(ADDR_RST_STAT, 8'h04);
      wrReg(ADDR_MISC_ONE, 8'h0F);
      rdChk(ADDR_MISC_ONE, 8'h0F);
      chk({29'h0, prescaleSel, slowMode}, 32'h7, "prescaler pins");
      endTest("registers");
      pulse(P_WDG);
      rdChk(ADDR_RST_STAT, 8'h05);
      pulse(P_LVD);
      rdChk(ADDR_RST_STAT, 8'h14);
      pulse(P_WDG);
      rdChk(ADDR_RST_STAT, 8'h15);
      wrReg(ADDR_RST_STAT, 8'h04);
      rdChk(ADDR_RST_STAT, 8'h04);
      endTest("reset flags");
      oscRun <= 1'h1;
      gap(cpuTick, 2 * OSC_CYC);
      gap(clkOut, 2 * OSC_CYC);
      endTest("clock out");
      wrReg(ADDR_CLK_CTRL, 8'h02);
      xfer(1'h0, ADDR_CLK_CTRL, 32'h0, r);
      waitSig(irq, 1'h0, 10);
      waitSig(irq, 1'h1, 2500);
      riseCyc = cyc;
      for (int s = 1; s < 4; s++) begin
         wrReg(ADDR_CLK_CTRL, {4'h0, 2'(s), 2'h2});
         period(DV[s-1] * OSC_CYC, 2'(s));
         period(DV[s] * OSC_CYC, 2'(s));
      end
      endTest("time base");
      xfer(1'h0, ADDR_CLK_CTRL, 32'h0, r);
      pulse(P_STOP);
      @(posedge clk);
      chk({30'h0, activeHalt, fullHalt}, 32'h2, "halt kind");
      r = {31'h0, clkOut};
      repeat (60) @(posedge clk);
      chk({31'h0, clkOut}, r, "frozen clock out");
      waitSig(activeHalt, 1'h0, 2500);
      chk({31'h0, irq}, 32'h1, "wake request");
      wrReg(ADDR_CLK_CTRL, 8'h00);
      pulse(P_STOP);
      @(posedge clk);
      chk({30'h0, activeHalt, fullHalt}, 32'h1, "halt kind");
      pulse(P_WAKE);
      @(posedge clk);
      chk({30'h0, activeHalt, fullHalt}, 32'h0, "run again");
      endTest("halt");
      guardEnable <= 1'h1;
      wrReg(ADDR_RST_STAT, 8'h04);
      oscHalf <= 8;
      waitSig(safeActive, 1'h1, 400);
      rdChk(ADDR_RST_STAT, 8'h06);
      rdChk(ADDR_RST_STAT, 8'h06);
      chk({31'h0, irq}, 32'h1, "loss request");
      oscHalf <= 40;
      waitSig(safeActive, 1'h0, 400);
      rdChk(ADDR_RST_STAT, 8'h06);
      rdChk(ADDR_RST_STAT, 8'h04);
      chk({31'h0, irq}, 32'h0, "loss request");
      oscRun <= 1'h0;
      waitSig(safeActive, 1'h1, 400);
      guardEnable <= 1'h0;
      @(posedge clk);
      rdChk(ADDR_RST_STAT, 8'h04);
      chk({31'h0, irq}, 32'h0, "loss request");
      repeat (100) @(posedge clk);
      chk({31'h0, safeActive}, 32'h0, "no fallback");
      endTest("guard");
      tally_and_finish();
   end
endmodule : cstb_top_tb
